// ### src/xbm_bus_master.v
`timescale 1ns/1ns
`include "xbm_map.vh"

// External parallel bus master with dynamic bus sizing
module xbm_bus_master
(
    core_clk,
    rst,
    req_valid,
    req_ready,
    req_addr,
    req_size,
    req_write,
    req_wdata,
    req_space,
    req_async,
    req_fast,
    req_fast_port16,
    req_lock,
    req_lock_keep,
    rsp_valid,
    rsp_err,
    rsp_rdata,
    addr_out,
    space_code,
    xfer_size_hi,
    xfer_size_lo,
    read_not_write,
    addr_strobe_n,
    data_strobe_n,
    locked_rmw_n,
    data_in,
    data_out,
    data_oe_n,
    size_ack_hi_n,
    size_ack_lo_n
);
    input wire core_clk;
    input wire rst;
    input wire req_valid;
    output wire req_ready;
    input wire [31:0] req_addr;
    input wire [1:0] req_size;
    input wire req_write;
    input wire [31:0] req_wdata;
    input wire [3:0] req_space;
    input wire req_async;
    input wire req_fast;
    input wire req_fast_port16;
    input wire req_lock;
    input wire req_lock_keep;
    output reg rsp_valid;
    output reg rsp_err;
    output reg [31:0] rsp_rdata;
    output reg [31:0] addr_out;
    output reg [3:0] space_code;
    output wire xfer_size_hi;
    output wire xfer_size_lo;
    output reg read_not_write;
    output wire addr_strobe_n;
    output wire data_strobe_n;
    output wire locked_rmw_n;
    input wire [`XBM_DATA_W-1:0] data_in;
    output reg [`XBM_DATA_W-1:0] data_out;
    output wire data_oe_n;
    input wire size_ack_hi_n;
    input wire size_ack_lo_n;

    reg [1:0] state_q; // Bus cycle state
    reg [2:0] rem_q; // Bytes left in operand
    reg [31:0] wbuf_q; // Write bytes, next one at top
    reg [31:0] rbuf_q; // Read bytes gathered so far
    reg async_q; // Operand uses synchronised inputs
    reg fast_q; // Operand uses fast termination
    reg fast16_q; // Port width under fast termination
    reg lock_q; // Read-modify-write lock held
    reg keep_q; // Lock survives end of operand
    reg [2:0] take_b; // Bytes moved by this cycle
    reg term_b; // Cycle terminates now
    reg port16_b; // Responding port is sixteen bits
    reg [31:0] rnext_b; // Read buffer after this cycle
    reg [31:0] wnext_b; // Write buffer after this cycle
    reg [31:0] walign_b; // New write operand, left aligned
    reg [2:0] rem_new_b; // Byte count of new operand
    wire [`XBM_IN_W-1:0] lvl; // Resolved input levels
    wire ack_hi; // Resolved acknowledges, active high
    wire ack_lo;
    wire [`XBM_DATA_W-1:0] din; // Resolved data bus
    wire misalign; // Wide operand at odd address
    wire accept; // Request taken this edge

    // Bytes one cycle can move on the port
    function [2:0] xbm_take;
        input a0;
        input [2:0] rem;
        input p16;
        begin
            if (p16 && !a0 && rem >= `XBM_REM_TWO)
                xbm_take = `XBM_REM_TWO;
            else
                xbm_take = `XBM_REM_ONE; // RULE2
        end
    endfunction

    // Operand byte count from the size code
    function [2:0] xbm_count;
        input [1:0] size;
        begin
            case (size)
                `XBM_SIZE_BYTE: xbm_count = `XBM_REM_ONE;
                `XBM_SIZE_WORD: xbm_count = `XBM_REM_TWO;
                `XBM_SIZE_THREE: xbm_count = `XBM_REM_THREE;
                default: xbm_count = `XBM_REM_LONG;
            endcase
        end
    endfunction

    // Input capture and optional synchroniser
    xbm_in_sync u_in_sync
    (
        .core_clk(core_clk),
        .rst(rst),
        .async_mode(async_q),
        .pin_in({size_ack_hi_n, size_ack_lo_n, data_in}),
        .level_out(lvl)
    );

    assign ack_hi = ~lvl[`XBM_IN_W-1]; // RULE13
    assign ack_lo = ~lvl[`XBM_IN_W-2]; // RULE13
    // Fast cycles end one clock after the strobe, before any capture
    // stage has seen the data, so they read the pins directly
    assign din = fast_q ? data_in : lvl[`XBM_DATA_W-1:0]; // RULE9

    // Only even addresses take more than one byte
    assign misalign = req_addr[0] && (req_size != `XBM_SIZE_BYTE); // RULE1
    assign req_ready = (state_q == `XBM_ST_IDLE);
    assign accept = req_valid && req_ready;

    // Size pins carry bytes remaining; four wraps to long code
    assign xfer_size_hi = rem_q[1]; // RULE15
    assign xfer_size_lo = rem_q[0]; // RULE15

    // Address strobe low from assert state until termination
    assign addr_strobe_n = !((state_q == `XBM_ST_ASRT) ||
        (state_q == `XBM_ST_WAIT)); // RULE6
    // Read or fast: both strobes together; other writes: data strobe a clock late
    assign data_strobe_n = !((state_q == `XBM_ST_WAIT) ||
        ((state_q == `XBM_ST_ASRT) &&
        (read_not_write || fast_q))); // RULE16
    assign data_oe_n = !(!read_not_write &&
        ((state_q == `XBM_ST_ASRT) || (state_q == `XBM_ST_WAIT)));
    assign locked_rmw_n = !lock_q;

    // Termination and byte steering for the current cycle
    always @*
    begin
        port16_b = fast_q ? fast16_q : ack_hi; // RULE14
        term_b = 1'b0;
        if (state_q == `XBM_ST_ASRT)
            term_b = fast_q; // RULE9
        else if (state_q == `XBM_ST_WAIT)
            term_b = fast_q || ack_hi || ack_lo; // RULE5
        take_b = xbm_take(addr_out[0], rem_q, port16_b); // RULE3
        // Narrow port and odd byte sit on different lanes
        if (take_b == `XBM_REM_TWO)
            rnext_b = {rbuf_q[15:0], din};
        else if (port16_b && addr_out[0])
            rnext_b = {rbuf_q[23:0], din[7:0]};
        else
            rnext_b = {rbuf_q[23:0], din[15:8]};
        if (take_b == `XBM_REM_TWO)
            wnext_b = {wbuf_q[15:0], 16'h0000};
        else
            wnext_b = {wbuf_q[23:0], 8'h00};
        rem_new_b = xbm_count(req_size);
        case (req_size)
            `XBM_SIZE_BYTE: walign_b = {req_wdata[7:0], 24'h000000};
            `XBM_SIZE_WORD: walign_b = {req_wdata[15:0], 16'h0000};
            `XBM_SIZE_THREE: walign_b = {req_wdata[23:0], 8'h00};
            default: walign_b = req_wdata;
        endcase
    end

    // Cycle sequencer, same whether or not another master owns the bus
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q <= `XBM_ST_IDLE;
            rem_q <= `XBM_REM_ONE;
            wbuf_q <= 32'h00000000;
            rbuf_q <= 32'h00000000;
            async_q <= 1'b0;
            fast_q <= 1'b0;
            fast16_q <= 1'b0;
            lock_q <= 1'b0;
            keep_q <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_rdata <= 32'h00000000;
            addr_out <= 32'h00000000;
            space_code <= 4'h0;
            read_not_write <= 1'b1;
            data_out <= 16'h0000;
        end
        else
        begin
            rsp_valid <= 1'b0;
            case (state_q) // RULE12
                `XBM_ST_IDLE:
                begin
                    if (accept && misalign)
                    begin
                        // Refused without any bus cycle
                        rsp_valid <= 1'b1; // RULE1
                        rsp_err <= 1'b1;
                    end
                    else if (accept)
                    begin
                        state_q <= `XBM_ST_ADDR;
                        addr_out <= req_addr;
                        space_code <= req_space;
                        rem_q <= rem_new_b;
                        wbuf_q <= walign_b;
                        rbuf_q <= 32'h00000000;
                        // Direction only changes between operands
                        read_not_write <= !req_write;
                        async_q <= req_async; // RULE7
                        fast_q <= req_fast;
                        fast16_q <= req_fast_port16;
                        lock_q <= req_lock;
                        keep_q <= req_lock && req_lock_keep;
                    end
                end
                `XBM_ST_ADDR:
                begin
                    state_q <= `XBM_ST_ASRT;
                    // Odd byte copied to both lanes for any port
                    if (addr_out[0])
                        data_out <= {wbuf_q[31:24], wbuf_q[31:24]};
                    else
                        data_out <= wbuf_q[31:16];
                end
                `XBM_ST_ASRT:
                begin
                    if (!term_b)
                        state_q <= `XBM_ST_WAIT; // RULE8
                end
                default:
                begin
                    // Wait state held until acknowledge seen
                end
            endcase
            if (term_b)
            begin
                rbuf_q <= rnext_b;
                wbuf_q <= wnext_b;
                if (rem_q == take_b)
                begin
                    state_q <= `XBM_ST_IDLE;
                    rsp_valid <= 1'b1;
                    rsp_err <= 1'b0;
                    rsp_rdata <= read_not_write ? rnext_b : 32'h00000000;
                    lock_q <= keep_q;
                end
                else
                begin
                    // Further cycle for the remaining bytes
                    state_q <= `XBM_ST_ADDR; // RULE3
                    rem_q <= rem_q - take_b;
                    addr_out <= addr_out + {29'h00000000, take_b};
                end
            end
        end
    end
endmodule // xbm_bus_master

// ### src/xbm_map.vh
// Behaviour
// RULE1: Word and long operands only at even addresses
// RULE2: Odd address gets single-byte transfers only
// RULE3: Eight-bit port splits operands into successive cycles
// RULE4: Devices answer with eight or sixteen bits
// RULE5: Addressed device sets cycle length by acknowledge
// RULE6: Separate address and data strobes are driven
// RULE7: Asynchronous mode synchronises inputs, adding latency; fast cycles still read the data pins unsynchronised
// RULE8: Synchronous mode skips synchroniser, three-clock cycle
// RULE9: Fast termination completes cycle in two clocks
// RULE10: Every input is captured at the sampling edge
// RULE11: Captured levels are resolved before any use; fast cycles use the data pins directly, with no capture stage
// RULE12: Cycles look identical whoever owns the bus
// RULE13: Device returns both acknowledges active low
// RULE14: Byte, word, long operands via size and acknowledges
// RULE15: Size outputs encode bytes remaining in operand
// RULE16: Write data strobe follows address strobe one clock; fast writes assert both strobes together
`ifndef XBM_MAP_VH
`define XBM_MAP_VH

// Operand size codes, same encoding as the size outputs
`define XBM_SIZE_BYTE 2'h1
`define XBM_SIZE_WORD 2'h2
`define XBM_SIZE_THREE 2'h3
`define XBM_SIZE_LONG 2'h0

// Bus cycle states
`define XBM_ST_IDLE 2'h0
`define XBM_ST_ADDR 2'h1
`define XBM_ST_ASRT 2'h2
`define XBM_ST_WAIT 2'h3

// Byte counts
`define XBM_REM_ONE 3'h1
`define XBM_REM_TWO 3'h2
`define XBM_REM_THREE 3'h3
`define XBM_REM_LONG 3'h4

// Pin widths
`define XBM_DATA_W 16
`define XBM_IN_W 18

`endif

// ### src/xbm_in_sync.v
`timescale 1ns/1ns
`include "xbm_map.vh"

// Input capture for acknowledges and data bus
module xbm_in_sync
(
    core_clk,
    rst,
    async_mode,
    pin_in,
    level_out
);
    input wire core_clk;
    input wire rst;
    input wire async_mode;
    input wire [`XBM_IN_W-1:0] pin_in;
    output wire [`XBM_IN_W-1:0] level_out;

    genvar gi;
    generate
        for (gi = 0; gi < `XBM_IN_W; gi = gi + 1)
        begin : g_bit
            reg smp_q; // Direct capture, used in synchronous mode
            reg meta_q; // First synchroniser stage, read only by res_q
            reg res_q; // Resolved level, asynchronous mode
            // Capture every edge; idle level is high for strobes
            always @(posedge core_clk)
            begin
                if (rst)
                begin
                    smp_q <= 1'b1;
                    meta_q <= 1'b1;
                    res_q <= 1'b1;
                end
                else
                begin
                    smp_q <= pin_in[gi]; // RULE10
                    meta_q <= pin_in[gi]; // RULE7
                    res_q <= meta_q; // RULE11
                end
            end
            // Extra stage costs a clock but makes async inputs safe
            assign level_out[gi] = async_mode ? res_q : smp_q; // RULE8
        end
    endgenerate
endmodule // xbm_in_sync

// ### test/xbm_props.sv
`timescale 1ns/1ns
// Bus-side timing checks for the bus master
module xbm_props
(
    input wire core_clk,
    input wire rst,
    input wire req_valid,
    input wire req_ready,
    input wire [31:0] req_addr,
    input wire [1:0] req_size,
    input wire req_async,
    input wire req_fast,
    input wire rsp_valid,
    input wire rsp_err,
    input wire [31:0] addr_out,
    input wire [3:0] space_code,
    input wire xfer_size_hi,
    input wire xfer_size_lo,
    input wire read_not_write,
    input wire addr_strobe_n,
    input wire data_strobe_n,
    input wire data_oe_n,
    input wire size_ack_hi_n,
    input wire size_ack_lo_n
);
    wire take = req_valid && req_ready;
    // Wide operand at odd address
    wire bad = take && req_addr[0] && req_size != 2'h1;
    wire ack = !size_ack_hi_n || !size_ack_lo_n;
    reg fast_q;
    reg async_q;
    // Mode kept per operand, since the inputs may move once taken
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            fast_q <= 1'b0;
            async_q <= 1'b0;
        end
        else if (take)
        begin
            fast_q <= req_fast;
            async_q <= req_async;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    misalign_err_a: assert property (bad |=> rsp_valid && rsp_err)
        else $error("wide odd operand not refused");
    misalign_quiet_a: assert property (bad |=> addr_strobe_n[*2])
        else $error("bus cycle for refused operand");
    first_cycle_a: assert property (take && !bad |=>
        addr_out == $past(req_addr) &&
        {xfer_size_hi, xfer_size_lo} == $past(req_size))
        else $error("first cycle address or size wrong");
    bus_stable_a: assert property (!addr_strobe_n && !$past(addr_strobe_n)
        |-> $stable(addr_out) && $stable(space_code) &&
        $stable(read_not_write) && $stable({xfer_size_hi, xfer_size_lo}))
        else $error("bus controls moved under address strobe");
    rd_strobes_a: assert property ($fell(addr_strobe_n) && read_not_write
        |-> !data_strobe_n) else $error("read data strobe late");
    wr_ds_lag_a: assert property ($fell(addr_strobe_n) && !read_not_write
        && !fast_q |-> data_strobe_n ##1 !data_strobe_n)
        else $error("write data strobe not one clock late");
    wr_drive_a: assert property (!addr_strobe_n && !read_not_write
        |-> !data_oe_n) else $error("write data not driven");
    fast_two_clk_a: assert property ($fell(addr_strobe_n) && fast_q
        |=> addr_strobe_n) else $error("fast cycle too long");
    sync_three_a: assert property (!addr_strobe_n && $rose(ack)
        && !fast_q && !async_q |=> !addr_strobe_n ##1 addr_strobe_n)
        else $error("synchronous cycle not three clocks");
    async_lag_a: assert property (!addr_strobe_n && $rose(ack)
        && !fast_q && async_q |=> !addr_strobe_n ##1 !addr_strobe_n
        ##1 addr_strobe_n)
        else $error("asynchronous cycle latency wrong");
    cover property (bad);
    cover property ($fell(addr_strobe_n) && fast_q);
    cover property ($fell(addr_strobe_n) && async_q && !read_not_write);
endmodule // xbm_props
bind xbm_bus_master xbm_props u_props (.*);

// ### test/xbm_dev_model.sv
`timescale 1ns/1ns
// Memory on the far side of the bus, eight or sixteen bits wide
module xbm_dev_model
(
    input wire core_clk,
    input wire port16,
    input wire [1:0] wait_n,
    input wire [31:0] addr_out,
    input wire xfer_size_hi,
    input wire xfer_size_lo,
    input wire read_not_write,
    input wire addr_strobe_n,
    input wire [15:0] data_out,
    output reg [15:0] data_in,
    output reg size_ack_hi_n,
    output reg size_ack_lo_n
);
    reg [7:0] mem [0:255]; // Low address byte only
    integer n_cyc; // Bus cycles seen
    integer cnt;
    wire [7:0] a = addr_out[7:0];
    initial
    begin
        for (cnt = 0; cnt < 256; cnt = cnt + 1)
            mem[cnt] = cnt * 8'h35 + 8'h11;
        n_cyc = 0;
        cnt = 0;
        data_in = 16'h0000;
        {size_ack_hi_n, size_ack_lo_n} = 2'h3;
    end
    always @(negedge addr_strobe_n)
        n_cyc = n_cyc + 1;
    // Answer at the falling edge after the programmed wait
    always @(negedge core_clk)
    begin
        if (addr_strobe_n)
        begin
            // Released lines never keep the last value
            {size_ack_hi_n, size_ack_lo_n} <= 2'h3;
            data_in <= ~data_in;
            cnt <= 0;
        end
        else if (cnt < wait_n)
            cnt <= cnt + 1;
        else if (size_ack_hi_n && size_ack_lo_n)
        begin
            size_ack_hi_n <= !port16;
            size_ack_lo_n <= port16;
            if (read_not_write)
                data_in <= !port16 ? {mem[a], ~mem[a]} : a[0] ?
                    {~mem[a], mem[a]} : {mem[a], mem[a + 8'h01]};
            else if (port16 && a[0])
                mem[a] <= data_out[7:0];
            else
            begin
                mem[a] <= data_out[15:8];
                if (port16 && {xfer_size_hi, xfer_size_lo} != 2'h1)
                    mem[a + 8'h01] <= data_out[7:0];
            end
        end
    end
endmodule // xbm_dev_model

// ### test/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the bus master
module tb_top;
    reg core_clk, rst, req_valid, req_write, req_async, req_fast;
    reg req_fast_port16, port16;
    reg [31:0] req_addr, req_wdata;
    reg [1:0] req_size, wait_n;
    reg [3:0] req_space;
    reg req_lock, req_lock_keep;
    reg lk; // Expected lock level held after an operand
    wire req_ready, rsp_valid, rsp_err, xfer_size_hi, xfer_size_lo;
    wire read_not_write, addr_strobe_n, data_strobe_n, locked_rmw_n;
    wire data_oe_n, size_ack_hi_n, size_ack_lo_n;
    wire [31:0] rsp_rdata, addr_out;
    wire [3:0] space_code;
    wire [15:0] data_in, data_out;
    reg [7:0] ref_mem [0:255]; // Expected memory contents
    integer mismatches, n_tests, cyc, i;
    xbm_bus_master dut (.*);
    xbm_dev_model mdl (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task summarize;
        begin
            $display("tests %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // One operand; expectations from the mirror memory
    task op(input [7:0] a, input [1:0] s, input w, f, y, p);
        integer n, k, c0, cy;
        reg [31:0] d, e;
        reg misal;
        begin
            n = (s == 2'h0) ? 4 : s;
            misal = a[0] && s != 2'h1;
            cy = misal ? 0 : !p ? n : a[0] ? 1 : (n + 1) / 2;
            d = $urandom;
            e = 0;
            for (k = 0; k < n; k = k + 1)
                e = {e[23:0], ref_mem[a + k[7:0]]};
            c0 = mdl.n_cyc;
            @(negedge core_clk);
            {req_valid, req_write, req_fast, req_async} = {1'b1, w, f, y};
            {req_fast_port16, port16} = {p, p};
            {req_addr, req_size, req_wdata} = {24'h0, a, s, d};
            req_space = $urandom;
            {req_lock, req_lock_keep} = $urandom_range(3);
            wait_n = f ? 2'h0 : $urandom_range(3);
            @(negedge core_clk);
            req_valid = 1'b0;
            k = 0;
            while (rsp_valid !== 1'b1 && k < 300)
            begin
                @(negedge core_clk);
                k = k + 1;
            end
            chk(rsp_valid, 1);
            chk(rsp_err, misal);
            chk(mdl.n_cyc - c0, cy);
            if (!misal)
                chk(rsp_rdata, w ? 0 : e);
            if (!misal)
                chk(space_code, req_space);
            // Refused operands leave the lock as it was
            if (!misal)
                lk = req_lock && req_lock_keep;
            chk(locked_rmw_n, !lk);
            for (k = 0; k < n && w && !misal; k = k + 1)
                ref_mem[a + k[7:0]] = d[8 * (n - 1 - k) +: 8];
        end
    endtask
    // Hang guard, far above the longest expected run
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    initial
    begin
        {rst, req_valid, req_write, req_async, req_fast} = 5'h10;
        {req_fast_port16, port16, wait_n, req_space} = 8'h00;
        {req_lock, req_lock_keep, lk} = 3'h0;
        {req_addr, req_wdata, req_size} = 66'h1;
        {mismatches, n_tests, cyc} = 0;
        i = $urandom(16091);
        for (i = 0; i < 256; i = i + 1)
            ref_mem[i] = i * 8'h35 + 8'h11;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        // Corners: refusals, odd byte, long operands on narrow ports
        op(8'h03, 2'h0, 0, 0, 0, 1);
        op(8'h05, 2'h2, 1, 0, 1, 0);
        op(8'h07, 2'h1, 1, 0, 0, 1);
        op(8'hfe, 2'h0, 1, 0, 1, 0);
        op(8'hfe, 2'h0, 0, 1, 0, 0);
        op(8'h40, 2'h3, 0, 0, 0, 1);
        repeat (80)
            op($urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
        summarize;
    end
endmodule // tb_top
